// File: verilog/mbmap_pkg.sv
// Package of constants and types for the Modbus register mapper
package mbmap_pkg;
  localparam int unsigned MBMAP_CLK_MHZ = 250;
  // Process data timeout delay, in units of 0.1 s
  localparam logic [31:0] MBMAP_PDT_DELAY_MIN = 32'h0000_01f4;
  localparam logic [31:0] MBMAP_PDT_DELAY_RST = 32'h0000_2710;
  // Cycles per tick: 0.1 s in ns times the clock MHz over 1000, product wrapped to 32 bits, giving 3525163 cycles
  localparam int unsigned MBMAP_TICK_NS = 100_000_000;
  localparam int unsigned MBMAP_TICK_CYC = MBMAP_TICK_NS * MBMAP_CLK_MHZ / 1000;
  // Fixed holding register locations
  localparam logic [15:0] MBMAP_LOC_CTRL = 16'h0002;
  localparam logic [15:0] MBMAP_LOC_STAT = 16'h000a;
  localparam logic [15:0] MBMAP_LOC_FREE = 16'h0014;
  // Event block layout
  localparam int unsigned MBMAP_EVT_REGS = 6;
  localparam int unsigned MBMAP_EVT_ACT_BIT = 15;
  localparam logic [2:0] MBMAP_CLS_INFO = 3'h2;
  localparam logic [2:0] MBMAP_CLS_WARN = 3'h3;
  localparam logic [2:0] MBMAP_CLS_FAULT = 3'h4;
  localparam int unsigned MBMAP_FLOAT_REGS = 2;
  // Modbus exception codes
  localparam logic [7:0] MBMAP_EXC_NONE = 8'h00;
  localparam logic [7:0] MBMAP_EXC_ADDR = 8'h02;
  localparam logic [7:0] MBMAP_EXC_FUNC = 8'h01;
  // Object spaces reached by a request
  typedef enum logic [1:0] {
    MBMAP_SP_COIL,
    MBMAP_SP_HOLD,
    MBMAP_SP_INPUT
  } mbmap_space_e;
  // Kind of source behind a mapping entry
  typedef enum logic [2:0] {
    MBMAP_SRC_NONE,
    MBMAP_SRC_PARAM,
    MBMAP_SRC_CONST,
    MBMAP_SRC_EVENT,
    MBMAP_SRC_FLOAT,
    MBMAP_SRC_STRING
  } mbmap_src_e;
  // Permission codes
  typedef enum logic [1:0] {
    MBMAP_PERM_ALL,
    MBMAP_PERM_RO,
    MBMAP_PERM_WO,
    MBMAP_PERM_NONE
  } mbmap_perm_e;
  // One mapping entry as configured
  typedef struct packed {
    logic valid;
    mbmap_space_e space;
    logic [15:0] loc;
    mbmap_src_e src;
    logic [15:0] span;
    logic [15:0] scale;
    logic perm_set;
    mbmap_perm_e perm;
    logic wdog1;
    logic [15:0] value;
  } mbmap_map_s;
endpackage

// File: verilog/mbmap_wdog_if.sv
// Interface between the mapper and its process data timeout monitor
interface mbmap_wdog_if;
  logic retrigger;
  logic [31:0] delay;
  logic expired;
  modport mapper (output retrigger, output delay, input expired);
  modport monitor (input retrigger, input delay, output expired);
endinterface

// File: verilog/mbmap_timeout.sv
// Process data timeout monitor counting in 0.1 s ticks
module mbmap_timeout #(
  parameter int unsigned TICK_CYC = mbmap_pkg::MBMAP_TICK_CYC
) (
  input wire logic ref_clk, // System clock
  input wire logic reset, // Async reset, active high
  mbmap_wdog_if.monitor wd // Retrigger and expiry
);
  import mbmap_pkg::*;
  logic [31:0] tick_ff, nxt_tick;
  logic [31:0] ticks_ff, nxt_ticks;
  logic exp_ff, nxt_exp;

  // Count ticks since the last watchdog write; flag when delay passed
  always_comb begin
    nxt_tick = tick_ff;
    nxt_ticks = ticks_ff;
    nxt_exp = exp_ff;
    if (wd.retrigger) begin
      nxt_tick = '0; // R2
      nxt_ticks = '0;
      nxt_exp = 1'b0;
    end else if (tick_ff == TICK_CYC - 1) begin
      nxt_tick = '0;
      if (ticks_ff + 32'h1 >= wd.delay) begin
        nxt_exp = 1'b1; // R3
      end else begin
        nxt_ticks = ticks_ff + 32'h1;
      end
    end else begin
      nxt_tick = tick_ff + 32'h1;
    end
  end

  // State registers
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      tick_ff <= '0;
      ticks_ff <= '0;
      exp_ff <= 1'b0;
    end else begin
      tick_ff <= nxt_tick;
      ticks_ff <= nxt_ticks;
      exp_ff <= nxt_exp;
    end
  end

  assign wd.expired = exp_ff;
endmodule

// File: verilog/mbmap_top.sv
// Modbus register mapper: decode, permissions, scaling, events, watchdog
// Notes on behaviour
// (R1) Parameter value shown divided by its scaling
// (R2) Watchdog-flagged write restarts timeout timer
// (R3) No flagged write within delay raises timeout
// (R4) Float parameter spans two consecutive registers
// (R5) Each event is six holding registers
// (R6) Newest event fills the first block
// (R7) Registers 0-3 hold timestamp digits
// (R8) Register 4: active flag high, class low
// (R9) Register 5 holds the event code
// (R10) Input registers are read-only 16-bit
// (R11) Locations cover full 16-bit range
// (R12) Input register may return a constant
// (R13) String spans registers by byte length
// (R14) Own permission else default full access
// (R15) Holding 2 control, 10 status, below 20 reserved
// (R16) Bad access gets exception, nothing stored
module mbmap_top #(
  parameter int unsigned N_MAP = 8,
  parameter int unsigned N_EVT = 4,
  parameter int unsigned TICK_CYC = mbmap_pkg::MBMAP_TICK_CYC
) (
  input wire logic ref_clk, // System clock
  input wire logic reset, // Async reset, active high
  input wire logic cfg_we, // Mapping table write strobe
  input wire logic [7:0] cfg_idx, // Mapping table entry index
  input wire mbmap_pkg::mbmap_map_s cfg_entry, // Mapping entry written
  input wire logic [31:0] pdt_delay, // Timeout delay in 0.1 s units
  input wire logic [N_MAP*32-1:0] param_vals, // Parameter values per entry
  input wire logic evt_push, // New event logged
  input wire logic [63:0] evt_time, // SS.SS, HHMM, MMDD, YYYY digits
  input wire logic evt_active, // Event active flag
  input wire logic [2:0] evt_class, // Event class code
  input wire logic [15:0] evt_code, // Application event code
  input wire logic [15:0] status_word, // Status word parameter
  input wire logic req_valid, // Modbus request strobe
  input wire logic req_write, // Request is a write
  input wire mbmap_pkg::mbmap_space_e req_space, // Object space
  input wire logic [15:0] req_addr, // Location
  input wire logic [15:0] req_wdata, // Write data
  output logic rsp_valid, // Answer strobe
  output logic [15:0] rsp_rdata, // Read data
  output logic [7:0] rsp_exc, // Exception code, zero if none
  output logic [15:0] ctrl_word, // Fieldbus control word
  output logic wr_valid, // Accepted write to mapped parameter
  output logic [7:0] wr_idx, // Entry written
  output logic [15:0] wr_data, // Value written, scaled back
  output logic pdt_timeout // Process data timeout event
);
  import mbmap_pkg::*;
  mbmap_map_s map_ff [N_MAP];
  mbmap_map_s nxt_map [N_MAP];
  logic [15:0] evt_ff [N_EVT][MBMAP_EVT_REGS];
  logic [15:0] nxt_evt [N_EVT][MBMAP_EVT_REGS];
  logic [$clog2(N_EVT+1)-1:0] evt_cnt_ff, nxt_evt_cnt;
  logic rsp_valid_ff, nxt_rsp_valid;
  logic [15:0] rsp_rdata_ff, nxt_rsp_rdata;
  logic [7:0] rsp_exc_ff, nxt_rsp_exc;
  logic [15:0] ctrl_ff, nxt_ctrl;
  logic wr_valid_ff, nxt_wr_valid;
  logic [7:0] wr_idx_ff, nxt_wr_idx;
  logic [15:0] wr_data_ff, nxt_wr_data;
  logic retrig_ff, nxt_retrig;
  logic [31:0] delay_ff, nxt_delay;
  logic hit;
  logic [7:0] hit_idx;
  logic [15:0] hit_off;
  logic [31:0] scaled;
  logic [31:0] evt_off;
  mbmap_wdog_if wd_if ();

  // Mapping table and event log storage
  always_comb begin
    nxt_map = map_ff;
    nxt_evt = nxt_evt_init();
    nxt_evt_cnt = evt_cnt_ff;
    nxt_delay = (pdt_delay < MBMAP_PDT_DELAY_MIN) ? MBMAP_PDT_DELAY_MIN : pdt_delay; // R3
    if (cfg_we && (32'(cfg_idx) < N_MAP)) begin
      nxt_map[cfg_idx[$clog2(N_MAP)-1:0]] = cfg_entry;
    end
    if (evt_push) begin
      // Shift older events down so the newest sits in block zero
      for (int i = N_EVT - 1; i > 0; i--) begin
        nxt_evt[i] = evt_ff[i-1]; // R6
      end
      nxt_evt[0][0] = evt_time[63:48]; // R7
      nxt_evt[0][1] = evt_time[47:32];
      nxt_evt[0][2] = evt_time[31:16];
      nxt_evt[0][3] = evt_time[15:0];
      nxt_evt[0][4] = {evt_active, 12'h000, evt_class}; // R8
      nxt_evt[0][5] = evt_code; // R9
      if (32'(evt_cnt_ff) < N_EVT) begin
        nxt_evt_cnt = evt_cnt_ff + 1'b1;
      end
    end
  end

  // All-zero packed event log, not used by the design
  function automatic logic [N_EVT*MBMAP_EVT_REGS*16-1:0] pack_dummy();
    return '0;
  endfunction

  function automatic void unused_fn();
  endfunction

  // Stored word of event block b, register r, for reads
  function automatic logic [15:0] evt_word(input int b, input int r);
    return evt_ff[b][r];
  endfunction

  // Lookup of request location against mapping spans
  always_comb begin
    hit = 1'b0;
    hit_idx = '0;
    hit_off = '0;
    for (int i = 0; i < N_MAP; i++) begin
      if (!hit && map_ff[i].valid && map_ff[i].space == req_space
          && req_addr >= map_ff[i].loc
          && 17'(req_addr) < 17'(map_ff[i].loc) + 17'(map_ff[i].span)) begin // R4 R5 R11 R13
        hit = 1'b1;
        hit_idx = 8'(i);
        hit_off = req_addr - map_ff[i].loc;
      end
    end
  end

  // Scaled value of the hit parameter
  always_comb begin
    scaled = param_vals[32*hit_idx +: 32];
    if (map_ff[hit_idx[$clog2(N_MAP)-1:0]].scale != 16'h0000) begin
      scaled = param_vals[32*hit_idx +: 32] / 32'(map_ff[hit_idx[$clog2(N_MAP)-1:0]].scale); // R1
    end
  end

  // Request handling: decode, permission check and answer
  always_comb begin
    mbmap_map_s e;
    int b;
    int r;
    e = map_ff[hit_idx[$clog2(N_MAP)-1:0]];
    b = 32'(hit_off) / MBMAP_EVT_REGS;
    r = 32'(hit_off) % MBMAP_EVT_REGS;
    evt_off = 32'(hit_off);
    nxt_rsp_valid = req_valid;
    nxt_rsp_rdata = '0;
    nxt_rsp_exc = MBMAP_EXC_NONE;
    nxt_ctrl = ctrl_ff;
    nxt_wr_valid = 1'b0;
    nxt_wr_idx = wr_idx_ff;
    nxt_wr_data = wr_data_ff;
    nxt_retrig = 1'b0;
    if (req_valid) begin
      if (req_space == MBMAP_SP_HOLD && req_addr < MBMAP_LOC_FREE) begin
        // Fixed low holding locations
        if (req_addr == MBMAP_LOC_CTRL) begin // R15
          if (req_write) begin
            nxt_ctrl = req_wdata;
          end else begin
            nxt_rsp_rdata = ctrl_ff;
          end
        end else if (req_addr == MBMAP_LOC_STAT && !req_write) begin
          nxt_rsp_rdata = status_word;
        end else begin
          nxt_rsp_exc = MBMAP_EXC_ADDR; // R16
        end
      end else if (!hit) begin
        nxt_rsp_exc = MBMAP_EXC_ADDR; // R16
      end else if (req_write) begin
        if (req_space == MBMAP_SP_INPUT || e.src == MBMAP_SRC_EVENT
            || e.src == MBMAP_SRC_CONST
            || (e.perm_set && (e.perm == MBMAP_PERM_RO || e.perm == MBMAP_PERM_NONE))) begin
          nxt_rsp_exc = MBMAP_EXC_FUNC; // R10 R14 R16
        end else begin
          nxt_wr_valid = 1'b1;
          nxt_wr_idx = hit_idx;
          nxt_wr_data = (e.scale > 16'h0001) ? 16'(req_wdata * e.scale) : req_wdata;
          nxt_retrig = e.wdog1; // R2
        end
      end else if (e.perm_set && (e.perm == MBMAP_PERM_WO || e.perm == MBMAP_PERM_NONE)) begin
        nxt_rsp_exc = MBMAP_EXC_FUNC; // R14
      end else begin
        case (e.src)
          MBMAP_SRC_CONST: nxt_rsp_rdata = e.value; // R12
          MBMAP_SRC_EVENT: begin
            if (b < 32'(evt_cnt_ff)) begin
              nxt_rsp_rdata = evt_word(b, r); // R5
            end
          end
          MBMAP_SRC_FLOAT: begin
            nxt_rsp_rdata = hit_off[0] ? param_vals[32*hit_idx +: 16]
                                       : param_vals[32*hit_idx + 16 +: 16]; // R4
          end
          MBMAP_SRC_STRING: begin
            nxt_rsp_rdata = (hit_off[0]) ? param_vals[32*hit_idx +: 16]
                                         : param_vals[32*hit_idx + 16 +: 16]; // R13
          end
          MBMAP_SRC_PARAM: nxt_rsp_rdata = scaled[15:0]; // R1
          default: nxt_rsp_exc = MBMAP_EXC_ADDR;
        endcase
      end
    end
  end

  // Constant zero flag, not used by the design
  function automatic logic nxt_evt_dummy();
    return 1'b0;
  endfunction

  // Storage registers
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < N_MAP; i++) begin
        map_ff[i] <= '0;
      end
      for (int i = 0; i < N_EVT; i++) begin
        for (int j = 0; j < MBMAP_EVT_REGS; j++) begin
          evt_ff[i][j] <= '0;
        end
      end
      evt_cnt_ff <= '0;
      delay_ff <= MBMAP_PDT_DELAY_RST;
    end else begin
      map_ff <= nxt_map;
      evt_ff <= nxt_evt;
      evt_cnt_ff <= nxt_evt_cnt;
      delay_ff <= nxt_delay;
    end
  end

  // Answer and output registers
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      rsp_valid_ff <= 1'b0;
      rsp_rdata_ff <= '0;
      rsp_exc_ff <= MBMAP_EXC_NONE;
      ctrl_ff <= '0;
      wr_valid_ff <= 1'b0;
      wr_idx_ff <= '0;
      wr_data_ff <= '0;
      retrig_ff <= 1'b0;
    end else begin
      rsp_valid_ff <= nxt_rsp_valid;
      rsp_rdata_ff <= nxt_rsp_rdata;
      rsp_exc_ff <= nxt_rsp_exc;
      ctrl_ff <= nxt_ctrl;
      wr_valid_ff <= nxt_wr_valid;
      wr_idx_ff <= nxt_wr_idx;
      wr_data_ff <= nxt_wr_data;
      retrig_ff <= nxt_retrig;
    end
  end

  // Next-value default for the event log
  function automatic logic [15:0] nxt_evt_init_w(input int b, input int r);
    return evt_ff[b][r];
  endfunction

  typedef logic [15:0] mbmap_log_t [N_EVT][MBMAP_EVT_REGS];
  function automatic mbmap_log_t nxt_evt_init();
    mbmap_log_t t;
    t = evt_ff;
    return t;
  endfunction

  // Watchdog hookup
  assign wd_if.retrigger = retrig_ff;
  assign wd_if.delay = delay_ff;

  mbmap_timeout #(
    .TICK_CYC(TICK_CYC)
  ) u_timeout (
    .ref_clk(ref_clk),
    .reset(reset),
    .wd(wd_if.monitor)
  );

  assign rsp_valid = rsp_valid_ff;
  assign rsp_rdata = rsp_rdata_ff;
  assign rsp_exc = rsp_exc_ff;
  assign ctrl_word = ctrl_ff;
  assign wr_valid = wr_valid_ff;
  assign wr_idx = wr_idx_ff;
  assign wr_data = wr_data_ff;
  assign pdt_timeout = wd_if.expired;
endmodule

// File: testbench/mbmap_assertions.sv
// Concurrent checks on the Modbus register mapper ports
module mbmap_checker
  import mbmap_pkg::*;
(
  input wire logic ref_clk, // Clock
  input wire logic reset, // Reset
  input wire logic req_valid, // Request
  input wire logic req_write, // Write flag
  input wire mbmap_pkg::mbmap_space_e req_space, // Space
  input wire logic [15:0] req_addr, // Location
  input wire logic [15:0] req_wdata, // Write data
  input wire logic [15:0] status_word, // Status
  input wire logic rsp_valid, // Answer
  input wire logic [15:0] rsp_rdata, // Read data
  input wire logic [7:0] rsp_exc, // Exception
  input wire logic [15:0] ctrl_word, // Control word
  input wire logic wr_valid // Parameter write
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  logic hold;
  logic ctrl_wr;
  // Holding space requests and control word writes
  assign hold = req_valid && req_space == MBMAP_SP_HOLD;
  assign ctrl_wr = hold && req_write && req_addr == MBMAP_LOC_CTRL;
  chk_rsp_follows: assert property (req_valid |=> rsp_valid)
    else $error("answer strobe missing");
  chk_rsp_single: assert property (!req_valid |=> !rsp_valid)
    else $error("answer strobe without request");
  chk_ctrl_write: assert property (ctrl_wr |=> ctrl_word == $past(req_wdata) && rsp_exc == 8'h00)
    else $error("control word not stored");
  chk_ctrl_read: assert property (hold && !req_write && req_addr == MBMAP_LOC_CTRL
    |=> rsp_rdata == ctrl_word && rsp_exc == 8'h00)
    else $error("control word read wrong");
  chk_stat_read: assert property (hold && !req_write && req_addr == MBMAP_LOC_STAT
    |=> rsp_rdata == $past(status_word))
    else $error("status word read wrong");
  chk_resv_addr: assert property (hold && req_addr < MBMAP_LOC_FREE && req_addr != MBMAP_LOC_CTRL
    && req_addr != MBMAP_LOC_STAT |=> rsp_exc == MBMAP_EXC_ADDR)
    else $error("reserved location not refused");
  chk_input_ro: assert property (req_valid && req_write && req_space == MBMAP_SP_INPUT
    |=> rsp_exc != 8'h00 && !wr_valid)
    else $error("input register write accepted");
  chk_ctrl_stable: assert property (!ctrl_wr |=> $stable(ctrl_word))
    else $error("control word changed without write");
  chk_exc_nostore: assert property (rsp_valid && rsp_exc != 8'h00 |-> !wr_valid)
    else $error("refused access stored a value");
endmodule

bind mbmap_top mbmap_checker i_mbmap_checker (.ref_clk(ref_clk), .reset(reset),
  .req_valid(req_valid), .req_write(req_write), .req_space(req_space), .req_addr(req_addr),
  .req_wdata(req_wdata), .status_word(status_word), .rsp_valid(rsp_valid),
  .rsp_rdata(rsp_rdata), .rsp_exc(rsp_exc), .ctrl_word(ctrl_word), .wr_valid(wr_valid));

// File: testbench/mbmap_client.sv
// Remote Modbus client model issuing one request at a time
module mbmap_client
  import mbmap_pkg::*;
(
  input wire logic ref_clk, // Clock
  output logic req_valid, // Request
  output mbmap_pkg::mbmap_space_e req_space, // Space
  output logic req_write, // Write flag
  output logic [15:0] req_addr, // Location
  output logic [15:0] req_wdata, // Write data
  input wire logic rsp_valid, // Answer
  input wire logic [15:0] rsp_rdata, // Read data
  input wire logic [7:0] rsp_exc // Exception
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle request lines
  initial begin
    req_valid = 1'b0;
    req_write = 1'b0;
    req_space = MBMAP_SP_HOLD;
    req_addr = 16'h0000;
    req_wdata = 16'h0000;
  end
  // One transfer; an answer missing after four edges returns exception ff
  task automatic xfer(input logic wr, input mbmap_space_e sp, input logic [15:0] a,
    input logic [15:0] d, output logic [15:0] rd, output logic [7:0] ex);
    @(posedge ref_clk);
    req_valid <= 1'b1;
    req_write <= wr;
    req_space <= sp;
    req_addr <= a;
    req_wdata <= d;
    @(posedge ref_clk);
    req_valid <= 1'b0;
    req_addr <= ~a; // Released lines show garbage
    req_wdata <= ~d;
    ex = 8'hff;
    rd = 16'h0000;
    for (int n = 0; n < 4; n++) begin
      @(posedge ref_clk);
      if (rsp_valid === 1'b1) begin
        rd = rsp_rdata;
        ex = rsp_exc;
        break;
      end
    end
  endtask
endmodule

// File: testbench/tb_modbus_register_mapper.sv
// Testbench for the Modbus register mapper
module tb_modbus_register_mapper;
  import mbmap_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk, reset, cfg_we, evt_push, evt_active, rsp_valid, wr_valid, pdt_timeout, req_valid;
  logic req_write;
  logic [7:0] cfg_idx, rsp_exc, wr_idx, ex;
  mbmap_map_s cfg_entry;
  mbmap_space_e req_space;
  logic [31:0] pdt_delay;
  logic [255:0] param_vals;
  logic [63:0] evt_time;
  logic [2:0] evt_class;
  logic [15:0] evt_code, status_word, req_addr, req_wdata, rsp_rdata, ctrl_word, wr_data, rd;
  int mismatches = 0;
  int n_checks = 0;
  // Design with short ticks
  mbmap_top #(.N_MAP(8), .N_EVT(4), .TICK_CYC(4)) i_mbmap_top (.ref_clk(ref_clk), .reset(reset),
    .cfg_we(cfg_we), .cfg_idx(cfg_idx), .cfg_entry(cfg_entry), .pdt_delay(pdt_delay),
    .param_vals(param_vals), .evt_push(evt_push), .evt_time(evt_time), .evt_active(evt_active),
    .evt_class(evt_class), .evt_code(evt_code), .status_word(status_word),
    .req_valid(req_valid), .req_write(req_write), .req_space(req_space), .req_addr(req_addr),
    .req_wdata(req_wdata), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .rsp_exc(rsp_exc),
    .ctrl_word(ctrl_word), .wr_valid(wr_valid), .wr_idx(wr_idx), .wr_data(wr_data),
    .pdt_timeout(pdt_timeout));
  // Remote client
  mbmap_client i_mbmap_client (.ref_clk(ref_clk), .req_valid(req_valid), .req_space(req_space),
    .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata), .rsp_exc(rsp_exc));
  // Clock
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Request through the client; a lost answer ends the run
  task automatic rq(input logic w, input mbmap_space_e s, input logic [15:0] a, input logic [15:0] d);
    i_mbmap_client.xfer(w, s, a, d, rd, ex);
    if (ex === 8'hff) begin
      mismatches++;
      give_verdict();
    end
  endtask
  task automatic put_map(input logic [7:0] i, input mbmap_map_s e);
    @(posedge ref_clk);
    cfg_we <= 1'b1;
    cfg_idx <= i;
    cfg_entry <= e;
    @(posedge ref_clk);
    cfg_we <= 1'b0;
  endtask
  task automatic push_evt(input logic [63:0] t, input logic a, input logic [2:0] c,
    input logic [15:0] k);
    @(posedge ref_clk);
    evt_push <= 1'b1;
    evt_time <= t;
    evt_active <= a;
    evt_class <= c;
    evt_code <= k;
    @(posedge ref_clk);
    evt_push <= 1'b0;
  endtask
  task automatic t_fixed();
    rq(1'b1, MBMAP_SP_HOLD, 16'h0002, 16'h1234);
    check("control word", ctrl_word, 16'h1234);
    rq(1'b0, MBMAP_SP_HOLD, 16'h0002, 16'h0000);
    check("control read", rd, 16'h1234);
    rq(1'b0, MBMAP_SP_HOLD, 16'h000a, 16'h0000);
    check("status read", rd, 16'h00c3);
    rq(1'b0, MBMAP_SP_HOLD, 16'h0013, 16'h0000);
    check("reserved exc", {8'h00, ex}, 16'h0002);
  endtask
  task automatic t_param();
    rq(1'b0, MBMAP_SP_HOLD, 16'h0014, 16'h0000);
    check("scaled read", rd, 16'h0019);
    rq(1'b1, MBMAP_SP_HOLD, 16'h0014, 16'h0007);
    check("wr strobe", {15'h0, wr_valid}, 16'h0001);
    check("wr data", wr_data, 16'h001c);
    check("wr index", {8'h00, wr_idx}, 16'h0000);
    rq(1'b0, MBMAP_SP_HOLD, 16'h0030, 16'h0000);
    check("string high", rd, 16'h4142);
    rq(1'b0, MBMAP_SP_HOLD, 16'h0031, 16'h0000);
    check("string low", rd, 16'h4344);
    rq(1'b0, MBMAP_SP_HOLD, 16'h0032, 16'h0000);
    check("after string exc", {8'h00, ex}, 16'h0002);
    rq(1'b0, MBMAP_SP_HOLD, 16'h0016, 16'h0000);
    check("float high", rd, 16'h4048);
    rq(1'b0, MBMAP_SP_HOLD, 16'h0017, 16'h0000);
    check("float low", rd, 16'hf5c3);
    rq(1'b0, MBMAP_SP_HOLD, 16'h0018, 16'h0000);
    check("after float exc", {8'h00, ex}, 16'h0002);
    rq(1'b0, MBMAP_SP_HOLD, 16'hffff, 16'h0000);
    check("top location", rd, 16'h5a5a);
    rq(1'b1, MBMAP_SP_HOLD, 16'hffff, 16'h0001);
    check("read only exc", {7'h00, wr_valid, ex}, 16'h0001);
    rq(1'b0, MBMAP_SP_INPUT, 16'h0000, 16'h0000);
    check("constant", rd, 16'hbeef);
    rq(1'b1, MBMAP_SP_INPUT, 16'h0000, 16'h0001);
    check("input write exc", {8'h00, ex}, 16'h0001);
  endtask
  task automatic t_event();
    logic [15:0] exp [13];
    push_evt(64'h3012_1045_0614_2024, 1'b1, MBMAP_CLS_WARN, 16'h0101);
    push_evt(64'h5999_2359_1231_2025, 1'b0, MBMAP_CLS_FAULT, 16'h0202);
    exp = '{16'h5999, 16'h2359, 16'h1231, 16'h2025, 16'h0004, 16'h0202,
      16'h3012, 16'h1045, 16'h0614, 16'h2024, 16'h8003, 16'h0101, 16'h0000};
    for (int i = 0; i < 13; i++) begin
      rq(1'b0, MBMAP_SP_HOLD, 16'h0064 + 16'(i), 16'h0000);
      check("event word", rd, exp[i]);
    end
  endtask
  task automatic t_timeout();
    rq(1'b1, MBMAP_SP_HOLD, 16'h0014, 16'h0001);
    repeat (1900) @(posedge ref_clk);
    check("early timeout", {15'h0, pdt_timeout}, 16'h0000);
    for (int n = 0; pdt_timeout !== 1'b1; n++) begin
      if (n > 250) begin
        mismatches++;
        give_verdict();
      end
      @(posedge ref_clk);
    end
    rq(1'b1, MBMAP_SP_HOLD, 16'h0014, 16'h0001);
    repeat (3) @(posedge ref_clk);
    check("timeout cleared", {15'h0, pdt_timeout}, 16'h0000);
  endtask
  // Main sequence
  initial begin
    {cfg_we, evt_push, evt_active, cfg_idx, evt_time, evt_class, evt_code} = '0;
    cfg_entry = '0;
    pdt_delay = MBMAP_PDT_DELAY_MIN;
    param_vals = '0;
    param_vals[95:0] = {32'h0000_5a5a, 32'h4048_f5c3, 32'h0000_0064};
    param_vals[191:160] = 32'h4142_4344;
    status_word = 16'h00c3;
    reset = 1'b1;
    repeat (20) @(posedge ref_clk);
    reset <= 1'b0;
    put_map(8'h00, '{1'b1, MBMAP_SP_HOLD, 16'h0014, MBMAP_SRC_PARAM, 16'h0001, 16'h0004,
      1'b0, MBMAP_PERM_ALL, 1'b1, 16'h0000});
    put_map(8'h01, '{1'b1, MBMAP_SP_HOLD, 16'h0016, MBMAP_SRC_FLOAT, 16'h0002, 16'h0001,
      1'b0, MBMAP_PERM_ALL, 1'b0, 16'h0000});
    put_map(8'h02, '{1'b1, MBMAP_SP_HOLD, 16'hffff, MBMAP_SRC_PARAM, 16'h0001, 16'h0001,
      1'b1, MBMAP_PERM_RO, 1'b0, 16'h0000});
    put_map(8'h03, '{1'b1, MBMAP_SP_INPUT, 16'h0000, MBMAP_SRC_CONST, 16'h0001, 16'h0001,
      1'b0, MBMAP_PERM_ALL, 1'b0, 16'hbeef});
    put_map(8'h04, '{1'b1, MBMAP_SP_HOLD, 16'h0064, MBMAP_SRC_EVENT, 16'h0012, 16'h0001,
      1'b0, MBMAP_PERM_ALL, 1'b0, 16'h0000});
    put_map(8'h05, '{1'b1, MBMAP_SP_HOLD, 16'h0030, MBMAP_SRC_STRING, 16'h0002, 16'h0001,
      1'b0, MBMAP_PERM_ALL, 1'b0, 16'h0000});
    t_fixed();
    t_param();
    t_event();
    t_timeout();
    give_verdict();
  end
endmodule
